// file: design/csms_pkg.sv
// Constants and state types for the clocked serial multi-slave channel
package csms_pkg;

	// Register byte addresses on the Avalon-MM slave
	localparam logic [4:0] CSMS_ADDR_TXBUF = 5'h00;
	localparam logic [4:0] CSMS_ADDR_RXBUF = 5'h04;
	localparam logic [4:0] CSMS_ADDR_BAUD = 5'h08;
	localparam logic [4:0] CSMS_ADDR_CTRL0 = 5'h0c;
	localparam logic [4:0] CSMS_ADDR_CTRL1 = 5'h10;
	localparam logic [4:0] CSMS_ADDR_MODE = 5'h14;

	// Control 0 fields
	localparam int CSMS_C0_SRC_LSB = 0;
	localparam int CSMS_C0_HS_PIN = 2;
	localparam int CSMS_C0_SH_EMPTY = 3;
	localparam int CSMS_C0_HS_DIS = 4;
	localparam int CSMS_C0_DRV_OD = 5;
	localparam int CSMS_C0_CPOL = 6;
	// Control 1 fields
	localparam int CSMS_C1_TE = 0;
	localparam int CSMS_C1_TX_EMPTY = 1;
	localparam int CSMS_C1_RE = 2;
	localparam int CSMS_C1_RX_DONE = 3;
	localparam int CSMS_C1_IRS = 4;
	// Mode register fields
	localparam int CSMS_MD_SMD_LSB = 0;
	localparam int CSMS_MD_CLOCK_SOURCE_SELECT = 3;
	localparam int CSMS_MD_CPHA = 4;
	// Receive buffer overrun flag position
	localparam int CSMS_RB_OVR = 8;

	// Serial mode field value that enables this mode
	localparam logic [2:0] CSMS_MODE_SPECIAL2 = 3'h1;
	// Frame size and bit indices
	localparam int CSMS_FRAME_BITS = 8;
	localparam logic [2:0] CSMS_LAST_BIT = 3'h7;
	localparam logic [2:0] CSMS_OVR_BIT = 3'h6;

	// Divider source selections and prescaler masks
	localparam logic [1:0] CSMS_SRC_F1 = 2'h0;
	localparam logic [1:0] CSMS_SRC_F2 = 2'h1;
	localparam logic [1:0] CSMS_SRC_F8 = 2'h2;
	localparam logic [4:0] CSMS_PRE_F2 = 5'h01;
	localparam logic [4:0] CSMS_PRE_F8 = 5'h07;
	localparam logic [4:0] CSMS_PRE_F32 = 5'h1f;

	// Reset values
	localparam logic [7:0] CSMS_RST_BAUD = 8'h00;
	localparam logic [2:0] CSMS_RST_SMD = 3'h0;

	typedef enum logic [1:0] {
		CSMS_IDLE = 2'b01,
		CSMS_RUN = 2'b10
	} csms_state_type;

	// Whole state of the channel core
	typedef struct packed {
		csms_state_type fsm;
		logic [7:0] tx_buf;
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic [7:0] rx_buf;
		logic [7:0] baud;
		logic [2:0] smd;
		logic [2:0] bitcnt;
		logic [1:0] src;
		logic tx_empty;
		logic sh_empty;
		logic rx_done;
		logic ovr;
		logic ovr_frm;
		logic te;
		logic re;
		logic irs;
		logic hs_pin;
		logic hs_dis;
		logic drv_od;
		logic cpol;
		logic cpha;
		logic clock_source_select;
		logic txd;
		logic sclk;
		logic sck_s1;
		logic sck_s2;
		logic rxd_s1;
		logic rxd_s2;
		logic lvl_prev;
		logic first;
		logic rx_act;
		logic ack;
		logic [31:0] rdata;
		logic tx_irq;
		logic rx_irq;
	} csms_core_type;

	localparam csms_core_type CSMS_CORE_RST = '{
		fsm: CSMS_IDLE, baud: CSMS_RST_BAUD, smd: CSMS_RST_SMD,
		tx_empty: 1'b1, sh_empty: 1'b1, txd: 1'b1, sclk: 1'b1,
		sck_s1: 1'b1, sck_s2: 1'b1, lvl_prev: 1'b1, default: '0};

	// Prescaler and half-period counter state
	typedef struct packed {
		logic [4:0] pre;
		logic [7:0] cnt;
		logic half;
	} csms_baud_type;

endpackage : csms_pkg

// file: design/csms_baud_gen.sv
// Prescaler and divider that pace the transfer clock in master mode
`timescale 1ns/1ps
`default_nettype none
module csms_baud_gen
	import csms_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic run_i,
	input wire logic [1:0] src_i,
	input wire logic [7:0] div_i,
	// Half-period enable pulse
	output logic half_tick_o
);

	csms_baud_type st_q;
	csms_baud_type st_d;
	logic src_tick;

	// Source enable for f1, f2, f8 or f32
	function automatic logic src_sel(input logic [1:0] s, input logic [4:0] p);
		case (s)
			CSMS_SRC_F1: src_sel = 1'b1;
			CSMS_SRC_F2: src_sel = (p & CSMS_PRE_F2) == CSMS_PRE_F2;
			CSMS_SRC_F8: src_sel = (p & CSMS_PRE_F8) == CSMS_PRE_F8;
			default: src_sel = p == CSMS_PRE_F32;
		endcase
	endfunction : src_sel

	assign src_tick = src_sel(src_i, st_q.pre);

	// Half period is div+1 source ticks, so the clock runs at fj/(2(n+1))
	always_comb begin
		st_d = st_q;
		st_d.pre = st_q.pre + 5'h01;
		st_d.half = 1'b0;
		if (!run_i) begin
			st_d.cnt = 8'h00;
		end else if (src_tick) begin
			if (st_q.cnt == div_i) begin
				st_d.cnt = 8'h00;
				st_d.half = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign half_tick_o = st_q.half;

	a_half_after_count: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		st_q.half |-> $past(run_i && src_tick && st_q.cnt == div_i))
		else $error("half tick without full divider count");

endmodule : csms_baud_gen
`default_nettype wire

// file: design/csms_core.sv
// Clocked serial channel for one master and several slaves, with Avalon-MM registers
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module csms_core
	import csms_pkg::*;
#(
	parameter int unsigned CHANNEL = 0
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Avalon-MM slave
	input wire logic [4:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// Shared control register bit for channels 0 and 1
	input wire logic shared_irs_i,
	// Transfer clock pin
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_o,
	// Data pins
	input wire logic rxd_i,
	output logic txd_o,
	output logic txd_oe_o,
	// Interrupt requests
	output logic tx_irq_o,
	output logic rx_irq_o
);

	csms_core_type st_q;
	csms_core_type st_d;
	logic half_tick;
	logic mode_on;
	logic master;
	logic running;
	logic irs_eff;
	logic open_drain;
	logic lvl;
	logic samp_e;
	logic drv_e;
	logic fr_done;
	logic load;
	logic bus_req;
	logic wr_en;
	logic wr_tx;

	// Assertions below share the system clock and reset
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	// Register read mux, zero for unmapped addresses
	function automatic logic [31:0] reg_read(input csms_core_type s, input logic [4:0] a);
		reg_read = 32'h0000_0000;
		case (a)
			CSMS_ADDR_TXBUF: reg_read[7:0] = s.tx_buf;
			CSMS_ADDR_RXBUF: begin
				reg_read[7:0] = s.rx_buf;
				reg_read[CSMS_RB_OVR] = s.ovr;
			end
			CSMS_ADDR_BAUD: reg_read[7:0] = s.baud;
			CSMS_ADDR_CTRL0: begin
				reg_read[CSMS_C0_SRC_LSB +: 2] = s.src;
				reg_read[CSMS_C0_HS_PIN] = s.hs_pin;
				reg_read[CSMS_C0_SH_EMPTY] = s.sh_empty;
				reg_read[CSMS_C0_HS_DIS] = s.hs_dis;
				reg_read[CSMS_C0_DRV_OD] = s.drv_od;
				reg_read[CSMS_C0_CPOL] = s.cpol;
			end
			CSMS_ADDR_CTRL1: begin
				reg_read[CSMS_C1_TE] = s.te;
				reg_read[CSMS_C1_TX_EMPTY] = s.tx_empty;
				reg_read[CSMS_C1_RE] = s.re;
				reg_read[CSMS_C1_RX_DONE] = s.rx_done;
				reg_read[CSMS_C1_IRS] = s.irs;
			end
			CSMS_ADDR_MODE: begin
				reg_read[CSMS_MD_SMD_LSB +: 3] = s.smd;
				reg_read[CSMS_MD_CLOCK_SOURCE_SELECT] = s.clock_source_select;
				reg_read[CSMS_MD_CPHA] = s.cpha;
			end
			default: reg_read = 32'h0000_0000;
		endcase
	endfunction : reg_read

	// Transfer clock pacing, the divider only counts while a master frame runs
	csms_baud_gen u_baud (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.run_i(running && master),
		.src_i(st_q.src),
		.div_i(st_q.baud),
		.half_tick_o(half_tick)
	);

	// Mode decode and edge detection on the effective transfer clock
	assign mode_on = st_q.smd == CSMS_MODE_SPECIAL2;
	assign master = !st_q.clock_source_select;
	assign running = st_q.fsm == CSMS_RUN;
	assign irs_eff = (CHANNEL == 2) ? st_q.irs : shared_irs_i;
	assign open_drain = (CHANNEL == 2) || st_q.drv_od;
	assign lvl = master ? st_q.sclk : st_q.sck_s2;
	assign samp_e = running && (st_q.cpol ? (!lvl && st_q.lvl_prev) : (lvl && !st_q.lvl_prev));
	assign drv_e = running && (st_q.cpol ? (lvl && !st_q.lvl_prev) : (!lvl && st_q.lvl_prev));
	assign fr_done = samp_e && st_q.bitcnt == CSMS_LAST_BIT;
	// Bus answers on the second edge: one wait cycle, then the access takes effect
	assign bus_req = read_i || write_i;
	assign wr_en = st_q.ack && write_i && byteenable_i[0];
	assign wr_tx = wr_en && address_i == CSMS_ADDR_TXBUF;
	// A buffer write in the same cycle defers the load, so no data is lost
	assign load = mode_on && !running && st_q.te && !st_q.tx_empty && !wr_tx;

	always_comb begin
		st_d = st_q;
		st_d.tx_irq = 1'b0;
		st_d.rx_irq = 1'b0;
		// Pin synchronisers; only the second stage is read
		st_d.sck_s1 = sclk_i;
		st_d.sck_s2 = st_q.sck_s1;
		st_d.rxd_s1 = rxd_i;
		st_d.rxd_s2 = st_q.rxd_s1;
		st_d.lvl_prev = lvl;
		// Bus handshake and registered read data
		st_d.ack = bus_req && !st_q.ack;
		if (bus_req && !st_q.ack) begin
			st_d.rdata = reg_read(st_q, address_i);
		end
		// Software writes and clears come first so hardware sets win
		if (wr_en) begin
			case (address_i)
				CSMS_ADDR_TXBUF: begin
					st_d.tx_buf = writedata_i[7:0];
					st_d.tx_empty = 1'b0;
				end
				CSMS_ADDR_BAUD: st_d.baud = writedata_i[7:0];
				CSMS_ADDR_CTRL0: begin
					st_d.src = writedata_i[CSMS_C0_SRC_LSB +: 2];
					st_d.hs_pin = writedata_i[CSMS_C0_HS_PIN];
					st_d.hs_dis = writedata_i[CSMS_C0_HS_DIS];
					st_d.drv_od = writedata_i[CSMS_C0_DRV_OD];
					st_d.cpol = writedata_i[CSMS_C0_CPOL];
				end
				CSMS_ADDR_CTRL1: begin
					st_d.te = writedata_i[CSMS_C1_TE];
					st_d.re = writedata_i[CSMS_C1_RE];
					st_d.irs = writedata_i[CSMS_C1_IRS];
					// Overrun is cleared by turning reception off
					if (!writedata_i[CSMS_C1_RE]) begin
						st_d.ovr = 1'b0;
					end
				end
				CSMS_ADDR_MODE: begin
					st_d.smd = writedata_i[CSMS_MD_SMD_LSB +: 3];
					st_d.clock_source_select = writedata_i[CSMS_MD_CLOCK_SOURCE_SELECT];
					st_d.cpha = writedata_i[CSMS_MD_CPHA];
				end
				default: st_d.rdata = st_q.rdata;
			endcase
		end
		// Reading the receive buffer clears the completion flag
		if (st_q.ack && read_i && address_i == CSMS_ADDR_RXBUF) begin
			st_d.rx_done = 1'b0;
		end
		// Frame engine
		case (st_q.fsm)
			CSMS_IDLE: begin
				st_d.sclk = !st_q.cpol;
				if (load) begin
					st_d.fsm = CSMS_RUN;
					st_d.tx_empty = 1'b1;
					st_d.sh_empty = 1'b0;
					st_d.rx_act = st_q.re;
					st_d.bitcnt = 3'h0;
					st_d.ovr_frm = 1'b0;
					st_d.tx_irq = !irs_eff;
					// Phase zero presents the first bit before the first edge
					if (!st_q.cpha) begin
						st_d.txd = st_q.tx_buf[7];
						st_d.tx_sh = {st_q.tx_buf[6:0], 1'b0};
						st_d.first = 1'b1;
					end else begin
						st_d.tx_sh = st_q.tx_buf;
						st_d.first = 1'b0;
					end
				end
			end
			CSMS_RUN: begin
				// No toggle at the closing sample, or a fast divider glitches the idle level
				if (master && half_tick && !fr_done) begin
					st_d.sclk = !st_q.sclk;
				end
				if (!mode_on) begin
					st_d.fsm = CSMS_IDLE;
					st_d.sh_empty = 1'b1;
				end else if (drv_e) begin
					if (st_q.first) begin
						st_d.first = 1'b0;
					end else begin
						st_d.txd = st_q.tx_sh[7];
						st_d.tx_sh = {st_q.tx_sh[6:0], 1'b0};
					end
				end else if (samp_e) begin
					st_d.rx_sh = {st_q.rx_sh[6:0], st_q.rxd_s2};
					st_d.bitcnt = st_q.bitcnt + 3'h1;
					if (st_q.rx_act && st_q.bitcnt == CSMS_OVR_BIT && st_q.rx_done) begin
						st_d.ovr = 1'b1;
						st_d.ovr_frm = 1'b1;
					end
					if (fr_done) begin
						st_d.fsm = CSMS_IDLE;
						st_d.sh_empty = 1'b1;
						st_d.tx_irq = irs_eff;
						if (st_q.rx_act) begin
							st_d.rx_buf = {st_q.rx_sh[6:0], st_q.rxd_s2};
							st_d.rx_done = 1'b1;
							st_d.rx_irq = !st_q.ovr_frm;
						end
					end
				end
			end
			default: st_d.fsm = CSMS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_q <= CSMS_CORE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Pin drive: open-drain pulls low only, push-pull drives while the mode is on
	assign txd_o = open_drain ? 1'b0 : st_q.txd;
	assign txd_oe_o = mode_on && (open_drain ? !st_q.txd : 1'b1);
	assign sclk_o = st_q.sclk;
	assign sclk_oe_o = mode_on && master;
	assign readdata_o = st_q.rdata;
	assign waitrequest_o = bus_req && !st_q.ack;
	assign tx_irq_o = st_q.tx_irq;
	assign rx_irq_o = st_q.rx_irq;

	// Drive edges seen since the last load, for the frame length check
	logic [3:0] drv_cnt_q;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || load) begin
			drv_cnt_q <= 4'h0;
		end else if (drv_e) begin
			drv_cnt_q <= drv_cnt_q + 4'h1;
		end
	end

	a_frame_eight_edges: assert property (fr_done |-> drv_cnt_q == 4'h8)
		else $error("frame ended without eight drive edges");
	a_slave_no_clock: assert property (st_q.clock_source_select |-> !sclk_oe_o)
		else $error("slave drives the clock pin");
	a_tx_start_cond: assert property ($fell(st_q.sh_empty) |-> $past(st_q.te && !st_q.tx_empty))
		else $error("frame started without enable or data");
	a_rx_start_cond: assert property ($rose(st_q.rx_act) |-> $past(st_q.re && st_q.te))
		else $error("reception started without both enables");
	a_txd_drive_edge: assert property (running && $past(running) && $changed(st_q.txd)
		|-> $past(drv_e))
		else $error("data changed off the drive edge");
	a_tx_irq_source: assert property (tx_irq_o |-> $past(irs_eff ? fr_done : load))
		else $error("transmit request at wrong moment");
	a_rx_irq_frame: assert property (fr_done && st_q.rx_act && !st_q.ovr_frm
		|=> rx_irq_o && st_q.rx_done)
		else $error("completed frame gave no receive request");
	a_overrun_seventh: assert property ($rose(st_q.ovr)
		|-> $past(samp_e && st_q.bitcnt == CSMS_OVR_BIT && st_q.rx_done))
		else $error("overrun set off the seventh bit");
	a_overrun_no_irq: assert property (fr_done && st_q.ovr_frm |=> !rx_irq_o)
		else $error("receive request raised on overrun frame");
	a_phase_first_bit: assert property (load && !st_q.cpha |=> st_q.txd == $past(st_q.tx_buf[7]))
		else $error("phase zero first bit not presented at load");
	a_open_drain_low: assert property (open_drain |-> !txd_o)
		else $error("open-drain output drives high");
	a_shift_empty_run: assert property (running ##1 running |-> !st_q.sh_empty)
		else $error("shift empty flag set during a frame");

endmodule : csms_core
`default_nettype wire

// file: test/csms_slave_model.sv
// Behavioural serial slave on the far side of the channel
`timescale 1ns/1ps
`default_nettype none
module csms_slave_model (
	// Pins
	input wire logic sclk_i,
	input wire logic mosi_i,
	input wire logic sel_i,
	output logic miso_o,
	// Setup
	input wire logic pol_i,
	input wire logic [7:0] tx_byte_i,
	output logic [7:0] rx_byte_o
);
	logic [7:0] sh = 8'h00;
	logic last = 1'b0;
	int drv_cnt = 0;
	initial rx_byte_o = 8'h00;
	// Load on select, which software drives from a port pin
	always @(posedge sel_i) begin
		sh = tx_byte_i;
		drv_cnt = 0;
	end
	// Sample on rising and drive on falling at polarity 0, swapped at 1
	always @(sclk_i) begin
		if (sel_i) begin
			if (sclk_i != pol_i) rx_byte_o = {rx_byte_o[6:0], mosi_i};
			else begin
				if (drv_cnt > 0) sh = {sh[6:0], 1'b0};
				drv_cnt++;
			end
		end
	end
	// Released line shows the inverse, never a stale bit
	always @(sel_i or sh) begin
		if (sel_i) begin
			miso_o = sh[7];
			last = sh[7];
		end else miso_o = ~last;
	end
endmodule : csms_slave_model
`default_nettype wire

// file: test/test_csms_core.sv
// Self-checking bench for the clocked serial multi-slave channel
`timescale 1ns/1ps
`default_nettype none
module test_csms_core;
	import csms_pkg::*;
	typedef struct packed {
		logic pol, pha, od, irs;
		logic [1:0] src;
		logic [7:0] baud, mo, so;
	} csms_row_type;
	logic sys_clk, rst_n, read, write, shared_irs, tb_sclk, sel, p_pol;
	logic waitrequest, sclk_o, sclk_oe, txd_o, txd_oe, tx_irq, rx_irq;
	logic sclk_prev = 1'b1;
	logic [4:0] address;
	logic [31:0] writedata, readdata, r;
	logic [7:0] p_tx, p_rx;
	wire sclk_line;
	wire txd_line;
	wire rxd_line;
	int fail_count, total_checks, cyc, last_tog, half, tog_cnt, tx_cnt, rx_cnt, t0, r0;
	int halves[5];
	csms_row_type rows[5];
	logic [4:0] ra[6] = '{CSMS_ADDR_CTRL0, CSMS_ADDR_CTRL1, CSMS_ADDR_MODE, CSMS_ADDR_BAUD,
		CSMS_ADDR_RXBUF, 5'h18};
	logic [31:0] rv[6] = '{32'h08, 32'h02, 32'h00, 32'h00, 32'h00, 32'h00};
	// Clock pin shared with the bench when the channel is a slave
	assign sclk_line = sclk_oe ? sclk_o : tb_sclk;
	// Pull-up on the data line when released
	assign txd_line = txd_oe ? txd_o : 1'b1;
	csms_core #(.CHANNEL(0)) uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .address_i(address),
		.read_i(read), .write_i(write), .byteenable_i(4'h1), .writedata_i(writedata),
		.readdata_o(readdata), .waitrequest_o(waitrequest), .shared_irs_i(shared_irs),
		.sclk_i(sclk_line), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe), .rxd_i(rxd_line),
		.txd_o(txd_o), .txd_oe_o(txd_oe), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
	csms_slave_model partner (.sclk_i(sclk_line), .mosi_i(txd_line), .sel_i(sel),
		.miso_o(rxd_line), .pol_i(p_pol), .tx_byte_i(p_tx), .rx_byte_o(p_rx));
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Cycle count, clock toggle spacing and pulse counts
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		sclk_prev <= sclk_o;
		if (sclk_o !== sclk_prev) begin
			half <= cyc - last_tog;
			last_tog <= cyc;
			tog_cnt <= tog_cnt + 1;
		end
		if (tx_irq === 1'b1) tx_cnt <= tx_cnt + 1;
		if (rx_irq === 1'b1) rx_cnt <= rx_cnt + 1;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One Avalon cycle; held until waitrequest is seen low at an edge
	task automatic bus(input logic [4:0] a, input logic wr, input logic [7:0] d);
		logic w;
		address <= a;
		writedata <= {24'h000000, d};
		if (wr) write <= 1'b1;
		else read <= 1'b1;
		// Sampled at the rising edge itself; only the watchdog ends a hang
		do begin
			@(posedge sys_clk);
			w = waitrequest;
			r = readdata;
		end while (w !== 1'b0);
		write <= 1'b0;
		read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	// Poll the shift-empty flag under a bound
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			bus(CSMS_ADDR_CTRL0, 1'b0, 8'h00);
			n++;
		end while (r[CSMS_C0_SH_EMPTY] !== 1'b1 && n < 400);
		// A frame that never ends counts against the run
		if (r[CSMS_C0_SH_EMPTY] !== 1'b1) fail_count++;
		bus(CSMS_ADDR_CTRL1, 1'b0, 8'h00);
	endtask : wait_done
	task automatic run_frame(input csms_row_type rw, input logic slave);
		p_pol <= rw.pol;
		p_tx <= rw.so;
		shared_irs <= rw.irs;
		bus(CSMS_ADDR_BAUD, 1'b1, rw.baud);
		bus(CSMS_ADDR_CTRL0, 1'b1, {1'b0, rw.pol, rw.od, 3'h4, rw.src});
		bus(CSMS_ADDR_MODE, 1'b1, {3'h0, rw.pha, slave, CSMS_MODE_SPECIAL2});
		sel <= 1'b1;
		bus(CSMS_ADDR_CTRL1, 1'b1, 8'h05);
		t0 = tx_cnt;
		bus(CSMS_ADDR_TXBUF, 1'b1, rw.mo);
		repeat (4) @(posedge sys_clk);
		check(32'(tx_cnt - t0), rw.irs ? 32'h0 : 32'h1);
		bus(CSMS_ADDR_CTRL0, 1'b0, 8'h00);
		check(r[CSMS_C0_SH_EMPTY], 1'b0);
		// Slow external clock, idle high for polarity 0
		if (slave) repeat (16) begin
			repeat (10) @(posedge sys_clk);
			tb_sclk <= ~tb_sclk;
		end
		wait_done();
		check(32'(tx_cnt - t0), 32'h1);
		sel <= 1'b0;
	endtask : run_frame
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// Watchdog well beyond the expected run
	initial begin
		#1500000;
		fail_count++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		rst_n <= 1'b0;
		read <= 1'b0;
		write <= 1'b0;
		address <= 5'h00;
		writedata <= 32'h0;
		shared_irs <= 1'b0;
		tb_sclk <= 1'b1;
		sel <= 1'b0;
		p_pol <= 1'b0;
		p_tx <= 8'h00;
		rows[0] = '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 8'h04, 8'ha5, 8'h3c};
		rows[1] = '{1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 8'h04, 8'h81, 8'h7e};
		rows[2] = '{1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 8'h04, 8'h5a, 8'hc3};
		rows[3] = '{1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 8'h09, 8'h01, 8'h80};
		rows[4] = '{1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 8'h04, 8'hff, 8'h00};
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		check(sclk_oe, 1'b0);
		check(txd_oe, 1'b0);
		// Reset values, with an ignored write to an unmapped place
		bus(5'h18, 1'b1, 8'hff);
		foreach (ra[i]) begin
			bus(ra[i], 1'b0, 8'h00);
			check(r, rv[i]);
		end
		// No start without transmit enable
		bus(CSMS_ADDR_MODE, 1'b1, {5'h00, CSMS_MODE_SPECIAL2});
		t0 = tog_cnt;
		bus(CSMS_ADDR_TXBUF, 1'b1, 8'ha5);
		repeat (40) @(posedge sys_clk);
		check(32'(tog_cnt - t0), 32'h0);
		bus(CSMS_ADDR_CTRL1, 1'b0, 8'h00);
		check(r, 32'h00);
		// Transmit alone: no reception without receive enable
		r0 = rx_cnt;
		bus(CSMS_ADDR_CTRL1, 1'b1, 8'h01);
		wait_done();
		check(r, 32'h03);
		check(32'(rx_cnt - r0), 32'h0);
		// Ordinary frames, one per row
		foreach (rows[i]) begin
			r0 = rx_cnt;
			run_frame(rows[i], 1'b0);
			halves[i] = half;
			check(32'(rx_cnt - r0), 32'h1);
			bus(CSMS_ADDR_RXBUF, 1'b0, 8'h00);
			check(r, {24'h000000, rows[i].so});
			check(p_rx, rows[i].mo);
		end
		check(halves[3], 2 * halves[0]);
		check(halves[4], 2 * halves[0]);
		check(halves[0], 32'h5);
		// Second frame with the first one unread
		r0 = rx_cnt;
		run_frame(rows[0], 1'b0);
		run_frame(rows[1], 1'b0);
		check(32'(rx_cnt - r0), 32'h1);
		bus(CSMS_ADDR_RXBUF, 1'b0, 8'h00);
		check(r[CSMS_RB_OVR], 1'b1);
		bus(CSMS_ADDR_CTRL1, 1'b1, 8'h01);
		bus(CSMS_ADDR_RXBUF, 1'b0, 8'h00);
		check(r[CSMS_RB_OVR], 1'b0);
		// Reset between frames brings the flags back to idle
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		check(sclk_oe, 1'b0);
		bus(CSMS_ADDR_CTRL0, 1'b0, 8'h00);
		check(r, 32'h08);
		// Slave on the external clock
		run_frame(rows[0], 1'b1);
		check(sclk_oe, 1'b0);
		bus(CSMS_ADDR_RXBUF, 1'b0, 8'h00);
		check(r, {24'h000000, rows[0].so});
		check(p_rx, rows[0].mo);
		report_and_stop();
	end
endmodule : test_csms_core
`default_nettype wire
